/* File: rtl/imsc_baud_tick.sv */
`timescale 1ns/1ns
`default_nettype none
module imsc_baud_tick import imsc_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [7:0] setting,
    output logic tick
);
    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } imsc_baud_state_t;

    imsc_baud_state_t cur;
    imsc_baud_state_t next_cur;
    logic [15:0] quarterLen;

    // A bit has four quarters, so the bit rate is clock / (4 x factor x divider)
    function automatic logic [15:0] quarterCycles(input logic [7:0] s);
        logic [15:0] div;
        div = SCL_DIV_BASE + {8'h00, s[5:0], 2'b00};
        case (s[7:6])
            2'b01: return div;
            2'b10: return {div[14:0], 1'b0};
            default: return {1'b0, div[15:1]};
        endcase
    endfunction

    assign quarterLen = quarterCycles(setting);

    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (!run) begin
            next_cur.count = 16'h0000;
        end else if (cur.count + 16'h0001 >= quarterLen) begin
            next_cur.count = 16'h0000;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.count = cur.count + 16'h0001;
        end
        if (rst) begin
            next_cur = '0;
        end
    end

    always_ff @(posedge clk) begin
        cur <= next_cur;
    end

    assign tick = cur.tick;
endmodule // imsc_baud_tick
`default_nettype wire

/* File: rtl/imsc_controller.sv */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Own address sits in bits 7:1, bit 0 reads zero; slave answers it.
// - Serial rate is clock / (4 x multiplier x divider).
// - Primary control: enable, irq enable, master, tx, ack control, restart.
// - Status: done, addressed, busy, arb lost, 0, direction, irq flag, ack.
// - Data write feeds next transmit byte; read returns last received byte.
// - Address byte lsb picks master receive or master transmit.
// - Master transfer starts only on a data write with master selected.
// - Slave work starts only on a matching incoming address.
// - Ten-bit addressing raises a dummy interrupt after the first byte.
// - Transfer-complete flag sets at the ninth clock's falling edge.
// - Interrupt is flag gated by enable; writing one clears the flag.
// - General call without acceptance gets no acknowledge, except in 7-bit mode with own address zero.
// - Module is disabled after reset and never resets the system.
module imsc_controller import imsc_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic irq
);
    typedef struct packed {
        logic [6:0] ownAddr;
        logic [7:0] clkDiv;
        logic enable;
        logic irqEnable;
        logic masterSel;
        logic txDir;
        logic txAckCtl;
        logic genCallAccept;
        logic addrExtEnable;
        logic [2:0] hiAddr;
        logic xferDone;
        logic addressed;
        logic busBusy;
        logic arbLost;
        logic slaveDir;
        logic intFlag;
        logic rxAck;
        logic [7:0] rxData;
        logic [7:0] txData;
        logic [7:0] shift;
        logic [3:0] bitCnt;
        logic sdaLow;
        logic slaveHold;
        logic tenMatched;
        logic masterRead;
        logic masterAddrPhase;
        imsc_mstate_t mstate;
        logic [1:0] quarter;
        imsc_sphase_t sphase;
        logic [7:0] rdData;
    } imsc_ctrl_state_t;

    imsc_ctrl_state_t cur;
    imsc_ctrl_state_t next_cur;

    logic sclLvl;
    logic sdaLvl;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic tick;
    logic run;
    logic masterActive;
    logic engaged;
    logic recvNow;
    logic accept;
    logic ackWanted;
    logic desiredLow;
    logic sclLowMaster;
    logic sdaOverride;
    logic overrideLow;
    logic [7:0] readMux;

    imsc_line_sync lineSync (
        .clk(clk),
        .rst(rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sclLvl(sclLvl),
        .sdaLvl(sdaLvl),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .startSeen(startSeen),
        .stopSeen(stopSeen)
    );

    imsc_baud_tick baudTick (
        .clk(clk),
        .rst(rst),
        .run(run),
        .setting(cur.clkDiv),
        .tick(tick)
    );

    // Address decode shared by the acknowledge drive and the end-of-byte update
    function automatic logic slaveAccept(input imsc_sphase_t phase, input logic [7:0] b,
                                         input logic [6:0] own, input logic [2:0] hi,
                                         input logic gc, input logic ext, input logic tenM);
        logic gcHit;
        gcHit = gc && (b == GENERAL_CALL_ADDR);
        case (phase)
            S_ADDR: begin
                if (ext) begin
                    return gcHit || ((b[7:3] == TEN_BIT_PREFIX) && (b[2:1] == hi[2:1]) && (!b[0] || tenM));
                end
                return gcHit || (b[7:1] == own);
            end
            S_ADDR2: return b == {hi[0], own};
            default: return 1'b0;
        endcase
    endfunction

    assign masterActive = cur.mstate != M_IDLE;
    assign engaged = masterActive || (cur.sphase inside {S_ADDR, S_ADDR2, S_DATA});
    assign recvNow = masterActive ? (!cur.masterAddrPhase && cur.masterRead)
                                  : !((cur.sphase == S_DATA) && cur.txDir);
    assign accept = slaveAccept(cur.sphase, cur.shift, cur.ownAddr, cur.hiAddr,
                                cur.genCallAccept, cur.addrExtEnable, cur.tenMatched);
    assign ackWanted = (masterActive || cur.sphase == S_DATA) ? !cur.txAckCtl : accept;

    // Value the engine wants on the data line while the clock is low
    always_comb begin
        if (!engaged) begin
            desiredLow = 1'b0;
        end else if (cur.bitCnt < ACK_SLOT) begin
            desiredLow = !recvNow && !cur.txData[~cur.bitCnt[2:0]];
        end else if (cur.bitCnt == ACK_SLOT) begin
            desiredLow = recvNow && ackWanted;
        end else begin
            desiredLow = cur.sdaLow;
        end
    end

    always_comb begin
        sclLowMaster = 1'b0;
        sdaOverride = 1'b0;
        overrideLow = 1'b0;
        unique case (cur.mstate)
            M_IDLE: ;
            M_START: begin
                sdaOverride = 1'b1;
                overrideLow = cur.quarter != 2'h0;
            end
            M_BIT: sclLowMaster = cur.quarter < 2'h2;
            M_HOLD: sclLowMaster = 1'b1;
            M_STOP: begin
                sclLowMaster = cur.quarter == 2'h0;
                sdaOverride = 1'b1;
                overrideLow = cur.quarter < 2'h2;
            end
            M_RSTART: begin
                sclLowMaster = cur.quarter == 2'h0;
                sdaOverride = 1'b1;
                overrideLow = cur.quarter >= 2'h2;
            end
            default: ;
        endcase
    end

    // Quarters count only once a released clock is seen high, so stretching slaves are honoured
    assign run = cur.enable && masterActive && (cur.mstate != M_HOLD) && (sclLowMaster || sclLvl);

    always_comb begin
        unique case (regAddr)
            REG_OWN_ADDR: readMux = {cur.ownAddr, 1'b0};
            REG_CLK_DIV: readMux = cur.clkDiv;
            REG_PRIMARY: readMux = {cur.enable, cur.irqEnable, cur.masterSel, cur.txDir,
                                    cur.txAckCtl, 3'h0};
            REG_STATUS: readMux = {cur.xferDone, cur.addressed, cur.busBusy, cur.arbLost,
                                   1'b0, cur.slaveDir, cur.intFlag, cur.rxAck};
            REG_DATA: readMux = cur.rxData;
            REG_ADDR_CFG: readMux = {cur.genCallAccept, cur.addrExtEnable, 3'h0, cur.hiAddr};
            default: readMux = 8'h00;
        endcase
    end

    always_comb begin
        next_cur = cur;
        next_cur.rdData = regRd ? readMux : 8'h00;

        // Software side first, so hardware events below win over clears
        if (regWr) begin
            unique case (regAddr)
                REG_OWN_ADDR: next_cur.ownAddr = regWrData[7:1];
                REG_CLK_DIV: next_cur.clkDiv = regWrData;
                REG_PRIMARY: begin
                    next_cur.enable = regWrData[CTRL_ENABLE];
                    next_cur.irqEnable = regWrData[CTRL_IRQ_EN];
                    next_cur.masterSel = regWrData[CTRL_MASTER];
                    next_cur.txDir = regWrData[CTRL_TX_DIR];
                    next_cur.txAckCtl = regWrData[CTRL_TX_ACK];
                    next_cur.addressed = 1'b0;
                    if (regWrData[CTRL_RESTART] && !regWrData[CTRL_MASTER]) begin
                        next_cur.arbLost = 1'b1;
                        next_cur.intFlag = 1'b1;
                    end else if (regWrData[CTRL_RESTART] && cur.mstate == M_HOLD) begin
                        next_cur.mstate = M_RSTART;
                        next_cur.quarter = 2'h0;
                    end
                    if (!regWrData[CTRL_MASTER] && masterActive && cur.mstate != M_STOP) begin
                        next_cur.mstate = M_STOP;
                        next_cur.quarter = 2'h0;
                    end
                end
                REG_STATUS: begin
                    if (regWrData[STAT_INT_FLAG]) begin
                        next_cur.intFlag = 1'b0;
                    end
                    if (regWrData[STAT_ARB_LOST]) begin
                        next_cur.arbLost = 1'b0;
                    end
                end
                REG_DATA: begin
                    next_cur.txData = regWrData;
                    next_cur.xferDone = 1'b0;
                    next_cur.slaveHold = 1'b0;
                    if (cur.masterAddrPhase || !masterActive) begin
                        next_cur.masterRead = regWrData[0];
                    end
                    if (cur.enable && cur.masterSel && !masterActive) begin
                        if (cur.busBusy) begin
                            next_cur.arbLost = 1'b1;
                            next_cur.intFlag = 1'b1;
                            next_cur.masterSel = 1'b0;
                        end else begin
                            next_cur.mstate = M_START;
                            next_cur.quarter = 2'h0;
                            next_cur.masterAddrPhase = 1'b1;
                        end
                    end else if (cur.mstate == M_HOLD && !recvNow) begin
                        next_cur.mstate = M_BIT;
                        next_cur.quarter = 2'h0;
                    end
                end
                REG_ADDR_CFG: begin
                    next_cur.genCallAccept = regWrData[CFG_GEN_CALL];
                    next_cur.addrExtEnable = regWrData[CFG_ADDR_EXT];
                    next_cur.hiAddr = regWrData[2:0];
                end
                default: ;
            endcase
        end
        if (regRd && regAddr == REG_DATA) begin
            next_cur.xferDone = 1'b0;
            next_cur.slaveHold = 1'b0;
            if (cur.mstate == M_HOLD && recvNow) begin
                next_cur.mstate = M_BIT;
                next_cur.quarter = 2'h0;
            end
        end

        if (tick) begin
            next_cur.quarter = cur.quarter + 2'h1;
            if (cur.quarter == 2'h3) begin
                unique case (cur.mstate)
                    M_START: next_cur.mstate = M_BIT;
                    M_STOP: next_cur.mstate = M_IDLE;
                    M_RSTART: begin
                        next_cur.mstate = M_HOLD;
                        next_cur.masterAddrPhase = 1'b1;
                    end
                    default: ;
                endcase
            end
        end

        if (!engaged) begin
            next_cur.sdaLow = 1'b0;
        end else if (!sclLvl) begin
            next_cur.sdaLow = desiredLow;
        end

        if (cur.enable && startSeen) begin
            next_cur.busBusy = 1'b1;
            next_cur.bitCnt = 4'h0;
            next_cur.sdaLow = cur.mstate inside {M_START, M_RSTART};
            next_cur.sphase = (cur.mstate inside {M_START, M_RSTART}) ? S_IDLE : S_ADDR;
        end

        if (cur.enable && cur.busBusy && sclRise) begin
            if (cur.bitCnt < ACK_SLOT) begin
                next_cur.shift = {cur.shift[6:0], sdaLvl};
            end
            if (cur.bitCnt == ACK_SLOT && !recvNow && engaged) begin
                next_cur.rxAck = sdaLvl;
            end
            if (cur.bitCnt < BYTE_END) begin
                next_cur.bitCnt = cur.bitCnt + 4'h1;
            end
            // Released the line yet someone holds it low: another master won
            if (masterActive && !cur.sdaLow && !sdaLvl && cur.bitCnt < BYTE_END
                && ((cur.bitCnt < ACK_SLOT) ? !recvNow : recvNow)) begin
                next_cur.arbLost = 1'b1;
                next_cur.intFlag = 1'b1;
                next_cur.masterSel = 1'b0;
                next_cur.mstate = M_IDLE;
                next_cur.sdaLow = 1'b0;
                next_cur.sphase = cur.masterAddrPhase ? S_ADDR : S_IGNORE;
            end
        end

        if (cur.enable && cur.busBusy && sclFall && cur.bitCnt == BYTE_END) begin
            next_cur.bitCnt = 4'h0;
            if (masterActive) begin
                next_cur.xferDone = 1'b1;
                next_cur.intFlag = 1'b1;
                next_cur.masterAddrPhase = 1'b0;
                next_cur.mstate = M_HOLD;
                next_cur.quarter = 2'h0;
                if (recvNow) begin
                    next_cur.rxData = cur.shift;
                end
            end else if (cur.sphase inside {S_ADDR, S_ADDR2, S_DATA}) begin
                next_cur.xferDone = 1'b1;
                if (cur.sphase == S_DATA || accept) begin
                    next_cur.intFlag = 1'b1;
                    next_cur.slaveHold = 1'b1;
                end
                if (recvNow) begin
                    next_cur.rxData = cur.shift;
                end
                if (cur.sphase != S_DATA) begin
                    if (!accept) begin
                        next_cur.sphase = S_IGNORE;
                    end else if (cur.sphase == S_ADDR && cur.addrExtEnable
                                 && cur.shift[7:3] == TEN_BIT_PREFIX && !cur.shift[0]) begin
                        next_cur.sphase = S_ADDR2;
                    end else begin
                        next_cur.sphase = S_DATA;
                        next_cur.addressed = 1'b1;
                        next_cur.slaveDir = cur.shift[0] && cur.sphase == S_ADDR;
                        if (cur.sphase == S_ADDR2) begin
                            next_cur.tenMatched = 1'b1;
                        end
                    end
                end
            end
        end

        if (cur.enable && stopSeen) begin
            next_cur.busBusy = 1'b0;
            next_cur.sphase = S_IDLE;
            next_cur.tenMatched = 1'b0;
            next_cur.slaveHold = 1'b0;
            if (masterActive && cur.mstate != M_STOP) begin
                next_cur.arbLost = 1'b1;
                next_cur.intFlag = 1'b1;
                next_cur.masterSel = 1'b0;
                next_cur.mstate = M_IDLE;
            end
        end

        if (!next_cur.enable) begin
            next_cur.mstate = M_IDLE;
            next_cur.sphase = S_IDLE;
            next_cur.slaveHold = 1'b0;
            next_cur.sdaLow = 1'b0;
            next_cur.busBusy = 1'b0;
        end

        if (rst) begin
            next_cur = '0;
            next_cur.ownAddr = OWN_ADDR_RESET[7:1];
            next_cur.clkDiv = CLK_DIV_RESET;
            next_cur.enable = PRIMARY_RESET[CTRL_ENABLE];
            next_cur.genCallAccept = ADDR_CFG_RESET[CFG_GEN_CALL];
            next_cur.addrExtEnable = ADDR_CFG_RESET[CFG_ADDR_EXT];
            next_cur.hiAddr = ADDR_CFG_RESET[2:0];
        end
    end

    always_ff @(posedge clk) begin
        cur <= next_cur;
    end

    // Open-drain lines: only ever pull low
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = sclLowMaster || cur.slaveHold;
    assign sdaOe = sdaOverride ? overrideLow : cur.sdaLow;
    assign irq = cur.intFlag && cur.irqEnable;
    assign regRdData = cur.rdData;
endmodule // imsc_controller
`default_nettype wire

/* File: rtl/imsc_line_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module imsc_line_sync import imsc_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclLvl,
    output logic sdaLvl,
    output logic sclRise,
    output logic sclFall,
    output logic startSeen,
    output logic stopSeen
);
    // Bit 0 is the clock line, bit 1 the data line
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] lvl;
        logic [1:0] prev;
    } imsc_sync_state_t;

    imsc_sync_state_t cur;
    imsc_sync_state_t next_cur;

    always_comb begin
        next_cur.meta = {sdaIn, sclIn};
        next_cur.lvl = cur.meta;
        next_cur.prev = cur.lvl;
        if (rst) begin
            next_cur = {SYNC_IDLE, SYNC_IDLE, SYNC_IDLE};
        end
    end

    always_ff @(posedge clk) begin
        cur <= next_cur;
    end

    assign sclLvl = cur.lvl[0];
    assign sdaLvl = cur.lvl[1];
    assign sclRise = cur.lvl[0] & ~cur.prev[0];
    assign sclFall = ~cur.lvl[0] & cur.prev[0];
    assign startSeen = cur.lvl[0] & cur.prev[0] & ~cur.lvl[1] & cur.prev[1];
    assign stopSeen = cur.lvl[0] & cur.prev[0] & cur.lvl[1] & ~cur.prev[1];
endmodule // imsc_line_sync
`default_nettype wire

/* File: rtl/imsc_pkg.sv */
package imsc_pkg;
    // Register map, byte-wide registers on a 3-bit index
    localparam logic [2:0] REG_OWN_ADDR = 3'h0;
    localparam logic [2:0] REG_CLK_DIV = 3'h1;
    localparam logic [2:0] REG_PRIMARY = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_DATA = 3'h4;
    localparam logic [2:0] REG_ADDR_CFG = 3'h5;

    // primary_control bits
    localparam int CTRL_ENABLE = 7;
    localparam int CTRL_IRQ_EN = 6;
    localparam int CTRL_MASTER = 5;
    localparam int CTRL_TX_DIR = 4;
    localparam int CTRL_TX_ACK = 3;
    localparam int CTRL_RESTART = 2;

    // bus_status bits
    localparam int STAT_DONE = 7;
    localparam int STAT_ADDRESSED = 6;
    localparam int STAT_BUSY = 5;
    localparam int STAT_ARB_LOST = 4;
    localparam int STAT_SLAVE_DIR = 2;
    localparam int STAT_INT_FLAG = 1;
    localparam int STAT_RX_ACK = 0;

    // address_config_control bits
    localparam int CFG_GEN_CALL = 7;
    localparam int CFG_ADDR_EXT = 6;

    localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
    localparam logic [7:0] CLK_DIV_RESET = 8'h00;
    localparam logic [7:0] PRIMARY_RESET = 8'h00;
    localparam logic [7:0] ADDR_CFG_RESET = 8'h00;

    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BYTE_END = 4'h9;

    // Serial-clock divider: base plus four per step of the low six setting bits
    localparam logic [15:0] SCL_DIV_BASE = 16'h0014;
    localparam logic [1:0] SYNC_IDLE = 2'h3;

    typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_HOLD, M_STOP, M_RSTART} imsc_mstate_t;
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR2, S_DATA, S_IGNORE} imsc_sphase_t;
endpackage

/* File: tb/imsc_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Slave receiver on pulled-up wires
module imsc_bus_model #(parameter logic [6:0] ADDR = 7'h52) (
    input wire logic scl,
    input wire logic sda,
    input wire logic slow,
    output logic sclLow,
    output logic sdaLow,
    output logic [7:0] lastByte,
    output logic stopSeen
);
    logic [3:0] bitCnt = 4'h0;
    logic [7:0] shift = 8'h00;
    logic active = 1'b0;
    logic first = 1'b0;
    logic host = 1'b0;
    logic mAck = 1'b0;
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        stopSeen = 1'b0;
    end
    always @(negedge sda) if (scl && !host) begin
        active = 1'b1;
        first = 1'b1;
        bitCnt = 4'h0;
        stopSeen = 1'b0;
    end
    always @(posedge sda) if (scl) begin
        active = 1'b0;
        stopSeen = 1'b1;
    end
    always @(posedge scl) if (active) begin
        if (bitCnt < 4'h8) shift = {shift[6:0], sda};
        bitCnt = bitCnt + 4'h1;
    end
    always @(negedge scl) if (active) begin
        if (bitCnt == 4'h8) begin
            lastByte = shift;
            sdaLow = !first || shift[7:1] == ADDR;
        end else if (bitCnt == 4'h9) begin
            sdaLow = 1'b0;
            bitCnt = 4'h0;
            first = 1'b0;
            sclLow = slow;
            #(slow ? 2000 : 0);
            sclLow = 1'b0;
        end
    end
    // Acting as bus master: start, one byte, ack sampled; honours a held clock
    task automatic host_byte(input logic [7:0] b);
        host = 1'b1;
        sdaLow = 1'b1;
        #1000;
        for (int i = 7; i >= -1; i--) begin
            sclLow = 1'b1;
            sdaLow = i >= 0 && !b[i[2:0]];
            #1000;
            sclLow = 1'b0;
            wait (scl);
            #1000;
            mAck = !sda;
        end
        sclLow = 1'b1;
        sdaLow = 1'b0;
        #1000;
    endtask
    task automatic host_stop;
        sdaLow = 1'b1;
        #1000;
        sclLow = 1'b0;
        wait (scl);
        #1000;
        sdaLow = 1'b0;
        host = 1'b0;
        #1000;
    endtask
endmodule // imsc_bus_model
`default_nettype wire

/* File: tb/imsc_controller_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module imsc_controller_chk import imsc_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdData,
    input wire logic sclIn,
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic en;
    logic ien;
    logic [11:0] sinceWr;
    // Enable bits change only by software writes
    always_ff @(posedge clk) begin
        if (rst) begin
            en <= 1'b0;
            ien <= 1'b0;
            sinceWr <= 12'hFFF;
        end else begin
            if (regWr && regAddr == REG_PRIMARY) begin
                en <= regWrData[CTRL_ENABLE];
                ien <= regWrData[CTRL_IRQ_EN];
            end
            sinceWr <= regWr ? 12'h000 : sinceWr + {11'h000, ~&sinceWr};
        end
    end
    sequence s_read(logic [2:0] a);
        regRd && regAddr == a;
    endsequence
    a_reset_quiet: assert property ($past(rst) |-> !sclOe && !sdaOe && !irq)
        else $error("pins driven after reset");
    a_off_silent: assert property (!en && !$past(en) |-> !sclOe && !sdaOe)
        else $error("disabled module drives bus");
    a_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside read slot");
    a_ctrl_low: assert property (s_read(REG_PRIMARY) |=> regRdData[2:0] == 3'h0)
        else $error("control low bits not zero");
    a_status_gap: assert property (s_read(REG_STATUS) |=> !regRdData[3])
        else $error("status bit 3 not zero");
    a_irq_masked: assert property (!ien |-> !irq)
        else $error("irq while masked");
    a_irq_flag: assert property (s_read(REG_STATUS) ##0 ien |=> regRdData[STAT_INT_FLAG] == $past(irq))
        else $error("irq differs from flag");
    a_start_cause: assert property ($rose(sdaOe) && sclIn && !sclOe |-> sinceWr < 12'h300)
        else $error("start without software write");
endmodule // imsc_controller_chk
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import imsc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic slow = 1'b0;
    logic [7:0] regRdData, mByte;
    logic sclOe, sdaOe, irq, mSclLow, mSdaLow, mStop;
    wire logic scl = !(sclOe || mSclLow);
    wire logic sda = !(sdaOe || mSdaLow);
    int fail_count = 0;
    int checked = 0;
    always #25 clk = !clk;
    imsc_controller i_dut (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .sclIn(scl),
        .sclOut(), .sclOe, .sdaIn(sda), .sdaOut(), .sdaOe, .irq);
    imsc_bus_model i_slave (.scl, .sda, .slow, .sclLow(mSclLow), .sdaLow(mSdaLow), .lastByte(mByte),
        .stopSeen(mStop));
    task automatic end_of_test;
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd_check(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        check(what, regRdData, exp);
    endtask
    task automatic wait_for(input logic which);
        int n;
        n = 0;
        while ((which ? mStop : irq) !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        check("awaited event", {7'h00, which ? mStop : irq}, 8'h01);
    endtask
    task automatic t_fields;
        logic [2:0] addr [5] = '{REG_OWN_ADDR, REG_CLK_DIV, REG_ADDR_CFG, REG_PRIMARY, 3'h6};
        logic [7:0] val [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h5B, 8'hFF};
        logic [7:0] exp [5] = '{8'hFE, 8'hFF, 8'hC7, 8'h58, 8'h00};
        for (int i = 0; i < 8; i++) rd_check("reset value", i[2:0], 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(addr[i], val[i]);
            rd_check("readback", addr[i], exp[i]);
        end
        wr(REG_CLK_DIV, 8'h00);
        wr(REG_ADDR_CFG, 8'h00);
    endtask
    task automatic t_master;
        wr(REG_PRIMARY, 8'hD0);
        wr(REG_PRIMARY, 8'hF0);
        wr(REG_DATA, 8'hA4);
        wait_for(1'b0);
        check("address on wire", mByte, 8'hA4);
        rd_check("status after address", REG_STATUS, 8'hA2);
        wr(REG_STATUS, 8'h02);
        @(posedge clk);
        check("irq after clear", {7'h00, irq}, 8'h00);
        slow <= 1'b1;
        wr(REG_DATA, 8'h3C);
        wait_for(1'b0);
        check("data on wire", mByte, 8'h3C);
        wr(REG_STATUS, 8'h02);
        // Drop master while the slave still stretches the clock
        wr(REG_PRIMARY, 8'hD0);
        wait_for(1'b1);
        repeat (4) @(posedge clk);
        rd_check("status after stop", REG_STATUS, 8'h80);
    endtask
    task automatic t_slave;
        wr(REG_ADDR_CFG, 8'h00);
        wr(REG_OWN_ADDR, 8'h66);
        wr(REG_PRIMARY, 8'hC0);
        i_slave.host_byte(GENERAL_CALL_ADDR);
        check("refused call ack", {7'h00, i_slave.mAck}, 8'h00);
        i_slave.host_stop;
        wr(REG_ADDR_CFG, 8'h80);
        i_slave.host_byte(GENERAL_CALL_ADDR);
        check("call ack", {7'h00, i_slave.mAck}, 8'h01);
        rd_check("status addressed", REG_STATUS, 8'hE2);
        rd_check("call byte", REG_DATA, GENERAL_CALL_ADDR);
        i_slave.host_stop;
        wr(REG_STATUS, 8'h02);
        wr(REG_PRIMARY, 8'hC0);
        wr(REG_ADDR_CFG, 8'h43);
        i_slave.host_byte(8'hF2);
        rd_check("dummy interrupt", REG_STATUS, 8'hA2);
        wr(REG_DATA, 8'h00);
        i_slave.host_stop;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_fields;
        t_master;
        t_slave;
        end_of_test;
    end
    initial begin
        #1000000;
        fail_count++;
        end_of_test;
    end
endmodule // tb
bind imsc_controller imsc_controller_chk i_chk (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .sclIn, .sclOe, .sdaOe, .irq);
`default_nettype wire
